// file: verilog/pwmds_top.sv
// module: pwm duty to position demand scaler with faults and filter
`default_nettype none
module pwmds_top (
  input  wire logic                  sys_clk_in,  // 50 MHz
  input  wire logic                  rst_b_in,    // async, active low
  input  wire pwmds_pkg::pwmds_cfg_s cfg_in,      // settings, quasi static
  input  wire logic                  duty_vld_in, // new measured duty, pulse
  input  wire logic [13:0]           duty_in,     // measured duty, 0.01 %
  output logic [13:0]                demand_out,  // position demand, 0.01 %
  output logic                       demand_vld_out, // demand updated, pulse; with filter on it leads demand_out by one cycle
  output logic                       fault_lo_out,   // duty below low threshold
  output logic                       fault_hi_out    // duty above high threshold
);
  // ==========================================================
  // settings clamped to legal ranges
  logic [13:0]        dmin, dmax, dlo, dhi, thl, thh;
  logic signed [15:0] ofs;
  logic [4:0]         fc;
  always_comb begin
    // out-of-range settings are clamped rather than rejected
    dmin = cfg_in.duty_min < pwmds_pkg::DUTY_CAL_LO ? pwmds_pkg::DUTY_CAL_LO :
           cfg_in.duty_min > pwmds_pkg::DUTY_CAL_HI ? pwmds_pkg::DUTY_CAL_HI : cfg_in.duty_min;
    dmax = cfg_in.duty_max < pwmds_pkg::DUTY_CAL_LO ? pwmds_pkg::DUTY_CAL_LO :
           cfg_in.duty_max > pwmds_pkg::DUTY_CAL_HI ? pwmds_pkg::DUTY_CAL_HI : cfg_in.duty_max;
    ofs  = cfg_in.duty_ofs < pwmds_pkg::OFS_LO ? pwmds_pkg::OFS_LO :
           cfg_in.duty_ofs > pwmds_pkg::OFS_HI ? pwmds_pkg::OFS_HI : cfg_in.duty_ofs;
    dlo  = cfg_in.dem_min > pwmds_pkg::DEM_MAX_DFLT ? pwmds_pkg::DEM_MAX_DFLT : cfg_in.dem_min;
    dhi  = cfg_in.dem_max > pwmds_pkg::DEM_MAX_DFLT ? pwmds_pkg::DEM_MAX_DFLT : cfg_in.dem_max;
    thl  = cfg_in.thr_lo < pwmds_pkg::LO_THR_LO ? pwmds_pkg::LO_THR_LO :
           cfg_in.thr_lo > pwmds_pkg::LO_THR_HI ? pwmds_pkg::LO_THR_HI : cfg_in.thr_lo;
    thh  = cfg_in.thr_hi < pwmds_pkg::HI_THR_LO ? pwmds_pkg::HI_THR_LO :
           cfg_in.thr_hi > pwmds_pkg::HI_THR_HI ? pwmds_pkg::HI_THR_HI : cfg_in.thr_hi;
    fc   = cfg_in.cutoff_hz < pwmds_pkg::FC_LO ? pwmds_pkg::FC_LO :
           cfg_in.cutoff_hz > pwmds_pkg::FC_HI ? pwmds_pkg::FC_HI : cfg_in.cutoff_hz;
  end

  // ==========================================================
  // stage 1: offset, faults
  logic               s1_vld_q, s1_vld_d;
  logic signed [15:0] corr_q, corr_d;
  logic               flo_q, flo_d, fhi_q, fhi_d;
  // strobe, corrected duty and fault levels; faults hold between samples
  always_comb begin
    s1_vld_d = duty_vld_in;
    corr_d   = corr_q;
    flo_d    = flo_q;
    fhi_d    = fhi_q;
    if (duty_vld_in) begin
      // offset corrected duty, floored at zero
      corr_d = $signed({2'b00, duty_in}) + ofs;
      if (corr_d < 16'sh0000) corr_d = 16'sh0000;
      // faults watch the measured duty, not the corrected one
      flo_d = duty_in < thl;
      fhi_d = duty_in > thh;
    end
  end
  // stage 1 registers; faults read clear while in reset
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s1_vld_q <= 1'b0;
      corr_q   <= 16'sh0000;
      flo_q    <= 1'b0;
      fhi_q    <= 1'b0;
    end else begin
      s1_vld_q <= s1_vld_d;
      corr_q   <= corr_d;
      flo_q    <= flo_d;
      fhi_q    <= fhi_d;
    end
  end

  // ==========================================================
  // stage 2: linear interpolation, works both ways round
  logic               s2_vld_q, s2_vld_d;
  logic [13:0]        scl_q, scl_d;
  logic signed [17:0] dx, span, dy;
  logic signed [35:0] prod;
  logic signed [35:0] yv;
  // next scaled demand, taken one edge after stage 1
  always_comb begin
    dx   = 18'(corr_q) - 18'($signed({4'h0, dmin}));
    span = 18'($signed({4'h0, dmax})) - 18'($signed({4'h0, dmin}));
    dy   = 18'($signed({4'h0, dhi})) - 18'($signed({4'h0, dlo}));
    prod = dx * dy;
    // equal points give no slope: hold demand at the min value
    yv   = (span == 18'sh00000) ? 36'sh0 : prod / span;
    yv   = yv + 36'($signed({4'h0, dlo}));
    // outside the points the line extends; clamp to 0..100 %
    if (yv < 36'sh0) yv = 36'sh0;
    if (yv > 36'(pwmds_pkg::FULL_SCALE)) yv = 36'(pwmds_pkg::FULL_SCALE);
    s2_vld_d = s1_vld_q;
    scl_d    = s1_vld_q ? yv[13:0] : scl_q;
  end
  // stage 2 registers; demand starts at the min-point default
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s2_vld_q <= 1'b0;
      scl_q    <= pwmds_pkg::DEM_MIN_DFLT;
    end else begin
      s2_vld_q <= s2_vld_d;
      scl_q    <= scl_d;
    end
  end

  // ==========================================================
  // 1 ms tick for the filter, fixed sample rate keeps alpha exact
  logic [15:0] tick_cnt_q, tick_cnt_d;
  logic        tick;
  // wrap the divider and raise the one-cycle tick
  always_comb begin
    tick       = tick_cnt_q == 16'(pwmds_pkg::FILT_TICK_CYC - 1);
    tick_cnt_d = tick ? 16'h0000 : tick_cnt_q + 16'h0001;
  end
  // divider counter runs free, filter enabled or not
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) tick_cnt_q <= 16'h0000;
    else           tick_cnt_q <= tick_cnt_d;
  end

  // ==========================================================
  // first-order low-pass, state in q16 fraction below 0.01 %
  logic [29:0]        filt_q, filt_d;
  logic signed [31:0] err;
  logic [15:0]        alpha;
  logic signed [48:0] step;
  logic [13:0]        dem_q, dem_d;
  logic               dvld_q, dvld_d;
  // filter step on each tick, or bypass straight from the scaler
  always_comb begin
    alpha  = 16'(fc * pwmds_pkg::Q_PER_HZ);
    err    = $signed({2'b00, scl_q, 16'h0000}) - $signed({2'b00, filt_q});
    step   = (err * $signed({1'b0, alpha})) >>> 16;
    filt_d = filt_q;
    if (!cfg_in.filt_en) begin
      // bypass keeps the state tracking so enabling causes no jump
      filt_d = {scl_q, 16'h0000};
    end else if (tick) begin
      filt_d = 30'($signed({2'b00, filt_q}) + step);
    end
    dem_d  = cfg_in.filt_en ? filt_q[29:16] : scl_q;
    dvld_d = cfg_in.filt_en ? tick : s2_vld_q;
  end
  // filter state and output registers
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      filt_q <= 30'h0;
      dem_q  <= 14'h0000;
      dvld_q <= 1'b0;
    end else begin
      filt_q <= filt_d;
      dem_q  <= dem_d;
      dvld_q <= dvld_d;
    end
  end

  // outputs come straight from registers, no logic after them
  assign demand_out     = dem_q;
  assign demand_vld_out = dvld_q;
  assign fault_lo_out   = flo_q;
  assign fault_hi_out   = fhi_q;

  // ==========================================================
  // checks
  // fault levels: set from the measured duty, held between samples
  chk_low_fault: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    duty_vld_in |=> (fault_lo_out == ($past(duty_in) < $past(thl))))
    else $error("low fault wrong");
  chk_high_fault: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    duty_vld_in |=> (fault_hi_out == ($past(duty_in) > $past(thh))))
    else $error("high fault wrong");
  chk_fault_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    !duty_vld_in |=> ($stable(fault_lo_out) && $stable(fault_hi_out)))
    else $error("fault changed without a sample");
  // bypass path: demand and strobe follow the scaled value
  chk_bypass_path: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (!cfg_in.filt_en && $past(!cfg_in.filt_en)) |-> ##1 (demand_out == $past(scl_q)))
    else $error("bypass demand wrong");
  chk_bypass_strobe: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (duty_vld_in && !cfg_in.filt_en) ##1 !cfg_in.filt_en ##1 !cfg_in.filt_en |=> demand_vld_out)
    else $error("bypass strobe missing");
  chk_demand_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (!demand_vld_out && !$past(cfg_in.filt_en) && !$past(cfg_in.filt_en, 2)) |-> $stable(demand_out))
    else $error("demand moved without a strobe");
  // scaling: range, the two calibration points and the offset
  chk_demand_range: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    demand_out <= pwmds_pkg::DEM_MAX_DFLT)
    else $error("demand over full scale");
  chk_min_point: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (s1_vld_q && corr_q == $signed({2'b00, dmin})) |=> (scl_q == $past(dlo)))
    else $error("demand at min point wrong");
  chk_max_point: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (s1_vld_q && dmin != dmax && corr_q == $signed({2'b00, dmax})) |=> (scl_q == $past(dhi)))
    else $error("demand at max point wrong");
  chk_offset_add: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (duty_vld_in && duty_in > 14'h07D0) |=> (corr_q == $signed({2'b00, $past(duty_in)}) + $past(ofs)))
    else $error("offset not added");
  // settings: clamped copies stay inside their ranges
  chk_cal_clamp: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    dmin >= pwmds_pkg::DUTY_CAL_LO && dmin <= pwmds_pkg::DUTY_CAL_HI &&
    dmax >= pwmds_pkg::DUTY_CAL_LO && dmax <= pwmds_pkg::DUTY_CAL_HI)
    else $error("calibration point out of range");
  chk_cutoff_range: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    fc >= pwmds_pkg::FC_LO && fc <= pwmds_pkg::FC_HI)
    else $error("cut-off out of range");
  chk_low_thr_range: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    thl >= pwmds_pkg::LO_THR_LO && thl <= pwmds_pkg::LO_THR_HI)
    else $error("low threshold out of range");
  chk_high_thr_range: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    thh >= pwmds_pkg::HI_THR_LO && thh <= pwmds_pkg::HI_THR_HI)
    else $error("high threshold out of range");
  // timing: the filter samples at a fixed slow rate
  chk_tick_rate: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    tick |=> !tick [*8])
    else $error("filter tick too fast");
endmodule : pwmds_top
`default_nettype wire

// file: verilog/pwmds_pkg.sv
// package: constants and types of the pwm demand scaler
`default_nettype none
package pwmds_pkg;
  // ==========================================================
  // number format: percent in units of 0.01 %
  localparam int unsigned           PCT_W        = 14;
  localparam logic signed [15:0]    FULL_SCALE   = 16'sh2710;  // 100.00 %
  // ==========================================================
  // setting limits and defaults
  localparam logic [13:0] DUTY_CAL_LO   = 14'h01F4;  // 5 %
  localparam logic [13:0] DUTY_CAL_HI   = 14'h251C;  // 95 %
  localparam logic [13:0] MIN_PT_DFLT   = 14'h03E8;  // 10 %
  localparam logic [13:0] MAX_PT_DFLT   = 14'h2328;  // 90 %
  localparam logic signed [15:0] OFS_LO = -16'sh07D0; // -20 %
  localparam logic signed [15:0] OFS_HI = 16'sh07D0;  // +20 %
  localparam logic [13:0] DEM_MIN_DFLT  = 14'h0000;  // 0 %
  localparam logic [13:0] DEM_MAX_DFLT  = 14'h2710;  // 100 %
  localparam logic [13:0] LO_THR_LO     = 14'h00C8;  // 2 %
  localparam logic [13:0] LO_THR_HI     = 14'h1388;  // 50 %
  localparam logic [13:0] HI_THR_LO     = 14'h1388;  // 50 %
  localparam logic [13:0] HI_THR_HI     = 14'h2648;  // 98 %
  localparam logic [4:0]  FC_LO         = 5'h01;     // 1 Hz
  localparam logic [4:0]  FC_HI         = 5'h14;     // 20 Hz
  localparam logic [4:0]  FC_DFLT       = 5'h14;     // 20 Hz
  // ==========================================================
  // filter timing: one update per ms, alpha = fc * 2 pi * dt in q16
  localparam int unsigned CLK_HZ        = 50000000;
  localparam int unsigned FILT_TICK_US  = 1000;
  localparam int unsigned FILT_TICK_CYC = CLK_HZ / 1000000 * FILT_TICK_US;
  localparam logic [15:0] Q_PER_HZ      = 16'h019C;  // 2 pi * 1 ms * 65536
  // ==========================================================
  // configuration bundle
  typedef struct packed {
    logic              filt_en;
    logic [4:0]        cutoff_hz;
    logic [13:0]       duty_min;
    logic [13:0]       duty_max;
    logic signed [15:0] duty_ofs;
    logic [13:0]       dem_min;
    logic [13:0]       dem_max;
    logic [13:0]       thr_lo;
    logic [13:0]       thr_hi;
  } pwmds_cfg_s;
endpackage : pwmds_pkg
`default_nettype wire

// file: dv/pwmds_pwm_src.sv
// partner model: controller presenting measured duty samples
`default_nettype none
module pwmds_pwm_src (
  input  wire logic        clk_in,   // bench clock
  output logic             vld_out,  // one-cycle sample strobe
  output logic [13:0]      duty_out  // measured duty, 0.01 %
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet line until the first sample
  initial begin
    vld_out  = 1'b0;
    duty_out = 14'h0000;
  end
  // ==========================================================
  // one sample, raised and dropped at falling edges
  task send(input logic [13:0] d);
    @(negedge clk_in);
    vld_out  = 1'b1;
    duty_out = d;
    @(negedge clk_in);
    vld_out  = 1'b0;
    // stale value inverted so nothing is read outside its strobe
    duty_out = ~d;
  endtask : send
endmodule : pwmds_pwm_src
`default_nettype wire

// file: dv/pwmds_top_tb_top.sv
// testbench: duty scaling, offset, reverse points, faults, filter
`default_nettype none
module pwmds_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  sys_clk_in = 1'b0;  // 50 MHz
  logic                  rst_b_in   = 1'b0;  // active low
  pwmds_pkg::pwmds_cfg_s cfg;                // settings
  logic                  duty_vld;           // from partner
  logic [13:0]           duty;               // from partner
  logic [13:0]           demand;             // scaled result
  logic                  demand_vld;         // result strobe
  logic                  fault_lo;           // low fault
  logic                  fault_hi;           // high fault
  int                    num_errors = 0;     // mismatches
  int                    samples_checked = 0;
  int                    cycles = 0;         // timeout count
  int                    i;
  always #10 sys_clk_in = ~sys_clk_in;
  pwmds_pwm_src pwmds_pwm_src_i (.clk_in(sys_clk_in), .vld_out(duty_vld), .duty_out(duty));
  pwmds_top pwmds_top_i (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .cfg_in(cfg),
    .duty_vld_in(duty_vld), .duty_in(duty), .demand_out(demand), .demand_vld_out(demand_vld),
    .fault_lo_out(fault_lo), .fault_hi_out(fault_hi));
  // ==========================================================
  // compare tasks
  task check_dem(input string n, input logic [13:0] e, input logic [13:0] s);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %0d seen %0d", n, e, s);
    end
  endtask : check_dem
  task check_bit(input string n, input logic e, input logic s);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %b seen %b", n, e, s);
    end
  endtask : check_bit
  task test_done;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  // ==========================================================
  // bypass demand and strobe stand in the cycle after the second edge past the take edge
  task scale(input logic [13:0] d, input logic [13:0] e);
    pwmds_pwm_src_i.send(d);
    repeat (2) @(negedge sys_clk_in);
    check_dem("demand", e, demand);
    check_bit("demand_vld", 1'b1, demand_vld);
  endtask : scale
  // faults settle on the take edge itself, checked a cycle later
  task flt(input logic [13:0] d, input logic lo, input logic hi);
    pwmds_pwm_src_i.send(d);
    @(negedge sys_clk_in);
    check_bit("fault_lo", lo, fault_lo);
    check_bit("fault_hi", hi, fault_hi);
  endtask : flt
  // hang guard: filter tick alone needs 50000 cycles
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 70000) begin
      num_errors++;
      test_done();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    cfg = '{1'b0, pwmds_pkg::FC_DFLT, pwmds_pkg::MIN_PT_DFLT, pwmds_pkg::MAX_PT_DFLT, 16'sh0000,
            pwmds_pkg::DEM_MIN_DFLT, pwmds_pkg::DEM_MAX_DFLT, pwmds_pkg::LO_THR_LO, pwmds_pkg::HI_THR_HI};
    repeat (8) @(negedge sys_clk_in);
    rst_b_in = 1'b1;
    scale(14'h03E8, 14'h0000);
    scale(14'h2328, 14'h2710);
    scale(14'h1388, 14'h1388);
    // beyond the points the line extends and is clamped to 0..100 %
    scale(14'h01F4, 14'h0000);
    scale(14'h251C, 14'h2710);
    cfg.duty_ofs = 16'sh03E8;
    scale(14'h0FA0, 14'h1388);
    cfg.duty_ofs = -16'sh07D0;
    scale(14'h1B58, 14'h1388);
    // offset beyond +20 % is held at +20 %
    cfg.duty_ofs = 16'sh0BB8;
    scale(14'h0BB8, 14'h1388);
    // low point below 5 % is held at 5 %
    cfg.duty_ofs = 16'sh0000;
    cfg.duty_min = 14'h0000;
    cfg.dem_min  = 14'h07D0;
    scale(14'h01F4, 14'h07D0);
    // reversed points: 90 % -> 20 %, 10 % -> 60 %
    cfg.duty_ofs = 16'sh0000;
    cfg.duty_min = 14'h2328;
    cfg.duty_max = 14'h03E8;
    cfg.dem_min  = 14'h07D0;
    cfg.dem_max  = 14'h1770;
    scale(14'h1B58, 14'h0BB8);
    scale(14'h0BB8, 14'h1388);
    // negative corrected duty is floored at zero before scaling
    cfg.duty_ofs = -16'sh07D0;
    scale(14'h03E8, 14'h1964);
    // offset present so a fault built on corrected duty shows up
    cfg.duty_ofs = 16'sh07D0;
    flt(14'h00C7, 1'b1, 1'b0);
    flt(14'h00C8, 1'b0, 1'b0);
    flt(14'h2649, 1'b0, 1'b1);
    flt(14'h2648, 1'b0, 1'b0);
    cfg.thr_lo = 14'h1388;
    cfg.thr_hi = 14'h1388;
    flt(14'h1387, 1'b1, 1'b0);
    flt(14'h1389, 1'b0, 1'b1);
    // filter: state parked at 0, step to full, one tick moves part way
    cfg = '{1'b0, pwmds_pkg::FC_DFLT, pwmds_pkg::MIN_PT_DFLT, pwmds_pkg::MAX_PT_DFLT, 16'sh0000,
            pwmds_pkg::DEM_MIN_DFLT, pwmds_pkg::DEM_MAX_DFLT, pwmds_pkg::LO_THR_LO, pwmds_pkg::HI_THR_HI};
    scale(14'h03E8, 14'h0000);
    cfg.filt_en = 1'b1;
    pwmds_pwm_src_i.send(14'h2328);
    for (i = 0; i < 50100 && demand_vld !== 1'b1; i++)
      @(negedge sys_clk_in);
    repeat (2) @(negedge sys_clk_in);
    check_bit("filt_step", 1'b1, demand > 14'h0000 && demand < 14'h1388);
    test_done();
  end
endmodule : pwmds_top_tb_top
`default_nettype wire
